// >>> tb_tdh_handler.sv
// Self-checking testbench for the transmit descriptor handler
`timescale 1ns/100ps
module tb_tdh_handler;
	import tdh_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [6:0] mev = 7'h00;
	logic hready, hreadyout, hresp, mem_req, mem_write, mem_ack, xfer_start, frame_add_checksum, transmitter_active;
	logic [31:0] hrdata, rd;
	logic [31:0] seed = 32'd32385;
	logic [23:0] mem_addr, xfer_addr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [11:0] xfer_len;
	int err_total = 0;
	int n_tests = 0;
	int idx;
	// Mode bits last written to the control register, for expectations
	logic nr = 1'b0;
	logic csd = 1'b1;

	// ***********************************************************
	// Clock, bus loop-back and instances
	// ***********************************************************
	always #10 core_clk = ~core_clk;
	assign hready = hreadyout;

	tdh_handler u_tdh_handler (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
		.xfer_len(xfer_len), .xfer_done(mev[5]), .frame_add_checksum(frame_add_checksum),
		.mac_collision(mev[0]), .mac_late_collision(mev[1]), .mac_carrier_lost(mev[2]), .mac_deferred(mev[3]),
		.mac_underflow(mev[4]), .mac_frame_done(mev[6]), .transmitter_active(transmitter_active));

	tdh_host_mem u_tdh_host_mem (.core_clk(core_clk), .reset(reset), .mem_req(mem_req), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// ***********************************************************
	// Helpers: random source, compare, verdict, bus cycles
	// ***********************************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Wait for a sampled high hready, never past a fixed bound
	task automatic hold();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			err_total++;
			conclude();
		end
	endtask

	// One single-word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		hold();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		hold();
		rd = hrdata;
		check(hresp, 1'b0);
	endtask

	// One-cycle pulse on a line from the transmitter side
	task automatic ev(input int k);
		mev[k] <= 1'b1;
		@(posedge core_clk);
		mev <= 7'h00;
		@(posedge core_clk);
	endtask

	// Bounded wait for a buffer move, or for ownership to come back
	task automatic wait_for(input int i, input logic own_clear);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge core_clk);
			if (own_clear ? u_tdh_host_mem.mem[i*4+1][15] === 1'b0 : xfer_start === 1'b1)
				break;
		end
		if (n == 400) begin
			err_total++;
			conclude();
		end
	endtask

	// ***********************************************************
	// One buffer: f = {underflow, last, force, deferred, lost carrier, late collision}
	// ***********************************************************
	task automatic frame(input int i, input int ncol, input logic [5:0] f, input logic [11:0] len);
		logic [31:0] r;
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		logic retry_limit_fault;
		logic chain;
		r = rnd();
		a = r[15:0];
		b = {2'b10, f[3], 3'b000, 1'b1, f[4], r[23:16]};
		c = {4'hf, 12'h000 - len};
		u_tdh_host_mem.mem[i*4] <= a;
		u_tdh_host_mem.mem[i*4+2] <= c;
		u_tdh_host_mem.mem[i*4+3] <= 16'h0000;
		@(posedge core_clk);
		u_tdh_host_mem.mem[i*4+1] <= b; // Ownership handed over only once the rest is in place
		wait_for(i, 1'b0);
		check(xfer_addr, {r[23:16], a});
		check(xfer_len, len);
		check(frame_add_checksum, f[3] | !csd);
		check(u_tdh_host_mem.mem[i*4+1][15], 1'b1);
		repeat (ncol) ev(0);
		if (f[0]) ev(1);
		if (f[1]) ev(2);
		if (f[2]) ev(3);
		if (f[5]) begin
			ev(4);
		end else begin
			ev(5);
			if (f[4]) ev(6);
		end
		wait_for(i, 1'b1);
		retry_limit_fault = ncol >= 16 || (nr && ncol > 0);
		chain = !f[4] && !f[5];
		check(u_tdh_host_mem.mem[i*4+1], {1'b0, f[0] | f[1] | f[5] | retry_limit_fault | chain, f[3], ncol > 1,
			ncol == 1 && !f[0] && !retry_limit_fault, f[2], 1'b1, f[4], r[23:16]});
		check(u_tdh_host_mem.mem[i*4+3], {chain && !f[0] && !retry_limit_fault, f[5] | chain, 1'b0, f[0], f[1], retry_limit_fault,
			10'h000});
		check(u_tdh_host_mem.mem[i*4], a);
		check(u_tdh_host_mem.mem[i*4+2], c);
		if (f[5] | chain) check(transmitter_active, 1'b0);
	endtask

	// ***********************************************************
	// Main sequence
	// ***********************************************************
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		check(transmitter_active, 1'b0);
		bus(1'b0, REG_RING_LEN, 32'h0);
		check(rd, RING_LEN_RST);
		bus(1'b1, REG_STATUS, 32'hffffffff);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 32'h10, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, REG_RING_BASE, 32'h100);
		bus(1'b0, REG_RING_BASE, 32'h0);
		check(rd, 32'h100);
		bus(1'b1, REG_CTRL, 32'h5);
		@(posedge core_clk);
		check(transmitter_active, 1'b1);
		// Retry counts 0,1,2,16, zero length, late collision with one retry
		for (int i = 0; i < 7; i++)
			frame(i, i == 5 ? 16 : i % 3, {1'b0, 1'b1, i[1], i[0], i == 3, i == 4}, i == 2 ? 12'h000 : 12'(rnd()));
		// Owned entry without first flag must be passed over
		u_tdh_host_mem.mem[29] <= 16'h8000;
		@(posedge core_clk);
		frame(0, 1, 6'b110000, 12'(rnd()));
		// Restart with retries disabled and checksum on by default
		nr = 1'b1;
		csd = 1'b0;
		bus(1'b1, REG_CTRL, 32'h3);
		bus(1'b0, REG_STATUS, 32'h0);
		idx = int'(rd[23:16]) % 8;
		// Chained buffer, next entry not owned; one collision trips the limit
		frame(idx, 1, 6'b000000, 12'(rnd()));
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd[23:0], {8'((idx + 1) % 8), 16'h0000});
		bus(1'b0, REG_CTRL, 32'h0);
		check(rd, 32'h2);
		conclude();
	end
endmodule

// >>> tdh_handler.sv
// Transmit descriptor handler with AHB-Lite control registers
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps

module tdh_handler #(
	parameter int RING_W = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic mem_req,
	output logic mem_write,
	output logic [23:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic xfer_start,
	output logic [23:0] xfer_addr,
	output logic [11:0] xfer_len,
	input wire logic xfer_done,
	output logic frame_add_checksum,
	input wire logic mac_collision,
	input wire logic mac_late_collision,
	input wire logic mac_carrier_lost,
	input wire logic mac_deferred,
	input wire logic mac_underflow,
	input wire logic mac_frame_done,
	output logic transmitter_active
);
	import tdh_pkg::*;

	tdh_state_e state;
	logic [15:0] word_a, word_b, nxt_b;
	logic [RING_W-1:0] idx, ring_len;
	logic [23:0] ring_base;
	logic no_retry, cs_dis;
	logic f_data_starved_fault, f_late_collision_fault, f_carrier_lost_fault, f_retry_limit_fault, f_chain, f_wait;
	logic [4:0] f_cnt;
	logic chain_ok, stop_req;
	logic wr_pend;
	logic [3:0] wr_addr;
	logic in_frame;
	logic addr_phase;
	logic [15:0] d_word, b_word;
	logic desc_end, frame_end;

	// ***********************************************************
	// Helpers
	// ***********************************************************
	function automatic logic [23:0] desc_addr(input logic [23:0] base, input logic [RING_W-1:0] i,
		input logic [23:0] off);
		desc_addr = base + (24'(i) << DESC_SHIFT) + off;
	endfunction
	function automatic logic [RING_W-1:0] step(input logic [RING_W-1:0] i, input logic [RING_W-1:0] len);
		step = (i + 1'b1 >= len) ? '0 : RING_W'(i + 1'b1);
	endfunction

	// Frame is on the wire while data moves or end status is awaited
	assign in_frame = (state == ST_MOVE) || (state == ST_NEXT_B) || (state == ST_WAIT_END);
	assign addr_phase = hsel && htrans[1] && hready;
	assign desc_end = (state == ST_WR_B) && mem_ack;
	assign frame_end = desc_end && (word_b[B_LAST] || stop_req || !chain_ok);

	// Status words handed back; fixed host fields copied unchanged
	assign d_word = {f_chain & ~(f_late_collision_fault | f_retry_limit_fault), f_data_starved_fault, 1'b0, f_late_collision_fault, f_carrier_lost_fault, f_retry_limit_fault, 10'h000};
	assign b_word = {1'b0, f_data_starved_fault | f_late_collision_fault | f_carrier_lost_fault | f_retry_limit_fault, word_b[B_FORCE],
		f_cnt > 5'h01,
		(f_cnt == 5'h01) && !f_late_collision_fault && !f_retry_limit_fault,
		f_wait, word_b[B_FIRST:0]};

	// ***********************************************************
	// AHB-Lite slave
	// ***********************************************************
	// Zero wait states, so response flops only need reset; write data lands in the data phase
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 4'h0;
		end else begin
			wr_pend <= addr_phase && hwrite;
			wr_addr <= haddr[3:0];
		end
	end
	// Configuration registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			no_retry <= 1'b0;
			cs_dis <= 1'b0;
			ring_base <= RING_BASE_RST;
			ring_len <= RING_W'(RING_LEN_RST);
		end else if (wr_pend) begin
			if (wr_addr == REG_CTRL) begin
				no_retry <= hwdata[CTRL_NO_RETRY];
				cs_dis <= hwdata[CTRL_CS_DIS];
			end
			if (wr_addr == REG_RING_BASE) ring_base <= hwdata[23:0];
			if (wr_addr == REG_RING_LEN) ring_len <= hwdata[RING_W-1:0];
		end
	end
	// Read data prepared in the address phase; only haddr[3:0] is decoded, unmapped offsets read as zero
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			unique case (haddr[3:0])
				REG_CTRL: hrdata <= {29'h0, cs_dis, no_retry, transmitter_active};
				REG_RING_BASE: hrdata <= {8'h00, ring_base};
				REG_RING_LEN: hrdata <= 32'(ring_len);
				REG_STATUS: hrdata <= {8'h00, 8'(idx), d_word[15:10], 5'h00, f_cnt};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end
	// Software starts or stops; a data fault stops it from hardware
	always_ff @(posedge core_clk) begin
		if (reset) begin
			transmitter_active <= 1'b0;
		end else if (in_frame && (mac_underflow || ((state == ST_NEXT_B) && mem_ack && !mem_rdata[B_OWN]))) begin
			transmitter_active <= 1'b0;
		end else if (wr_pend && (wr_addr == REG_CTRL)) begin
			transmitter_active <= hwdata[CTRL_START];
		end
	end
	// ***********************************************************
	// Fault and retry capture for the running frame
	// ***********************************************************
	// Faults other than the retry limit belong to the descriptor in use; counts and the retry limit to the frame
	always_ff @(posedge core_clk) begin
		if (reset || desc_end) begin
			f_data_starved_fault <= 1'b0;
			f_late_collision_fault <= 1'b0;
			f_carrier_lost_fault <= 1'b0;
			f_chain <= 1'b0;
		end else if (in_frame) begin
			if (mac_underflow) f_data_starved_fault <= 1'b1;
			if (mac_late_collision) f_late_collision_fault <= 1'b1;
			if (mac_carrier_lost) f_carrier_lost_fault <= 1'b1;
			if ((state == ST_NEXT_B) && ((mem_ack && !mem_rdata[B_OWN]) || mac_underflow)) begin
				f_chain <= 1'b1;
				f_data_starved_fault <= 1'b1;
			end
		end
	end
	// Failed attempts counted until the limit or the first when disabled
	always_ff @(posedge core_clk) begin
		if (reset || frame_end) begin
			f_cnt <= 5'h00;
			f_retry_limit_fault <= 1'b0;
			f_wait <= 1'b0;
		end else if (in_frame) begin
			if (mac_collision && !f_retry_limit_fault) begin
				f_cnt <= f_cnt + 5'h01;
				if ((f_cnt + 5'h01 >= RETRY_LIMIT) || no_retry) f_retry_limit_fault <= 1'b1;
			end
			if (mac_deferred) f_wait <= 1'b1;
		end
	end
	// ***********************************************************
	// Descriptor walk
	// ***********************************************************
	// One request held on the memory port until acknowledged
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= ST_IDLE;
			idx <= '0;
			word_a <= 16'h0000;
			word_b <= 16'h0000;
			nxt_b <= 16'h0000;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= 24'h000000;
			mem_wdata <= 16'h0000;
			xfer_start <= 1'b0;
			xfer_addr <= 24'h000000;
			xfer_len <= 12'h000;
			frame_add_checksum <= 1'b0;
			chain_ok <= 1'b0;
			stop_req <= 1'b0;
		end else begin
			xfer_start <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (transmitter_active) begin
						state <= ST_RD_B;
						mem_req <= 1'b1;
						mem_write <= 1'b0;
						mem_addr <= desc_addr(ring_base, idx, OFF_B);
					end
				end
				ST_RD_B: begin
					if (mem_ack) begin
						word_b <= mem_rdata;
						chain_ok <= 1'b0;
						stop_req <= 1'b0;
						if (!mem_rdata[B_OWN]) begin
							state <= ST_IDLE;
							mem_req <= 1'b0;
						end else if (!mem_rdata[B_FIRST]) begin
							idx <= step(idx, ring_len);
							state <= ST_IDLE;
							mem_req <= 1'b0;
						end else begin
							state <= ST_RD_A;
							mem_addr <= desc_addr(ring_base, idx, OFF_A);
						end
					end
				end
				ST_RD_A: begin
					if (mem_ack) begin
						word_a <= mem_rdata;
						state <= ST_RD_C;
						mem_addr <= desc_addr(ring_base, idx, OFF_C);
					end
				end
				ST_RD_C: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						state <= ST_MOVE;
						xfer_start <= 1'b1;
						xfer_addr <= {word_b[7:0], word_a};
						xfer_len <= 12'(~mem_rdata[C_LEN_HI:0] + 12'h001);
						if (word_b[B_FIRST]) begin
							frame_add_checksum <= word_b[B_FORCE] || !cs_dis;
						end
					end
				end
				ST_MOVE: begin
					if (mac_underflow) begin
						stop_req <= 1'b1;
						state <= ST_WR_D;
						mem_write <= 1'b1;
						mem_addr <= desc_addr(ring_base, idx, OFF_D);
					end else if (xfer_done && word_b[B_LAST]) begin
						state <= ST_WAIT_END;
					end else if (xfer_done) begin
						state <= ST_NEXT_B;
						mem_req <= 1'b1;
						mem_write <= 1'b0;
						mem_addr <= desc_addr(ring_base, step(idx, ring_len), OFF_B);
					end
				end
				ST_NEXT_B: begin
					if (mac_underflow) begin
						stop_req <= 1'b1;
					end
					if (mem_ack) begin
						nxt_b <= mem_rdata;
						chain_ok <= mem_rdata[B_OWN] && !mac_underflow && !stop_req;
						state <= ST_WR_D;
						mem_req <= 1'b0;
						mem_write <= 1'b1;
						mem_addr <= desc_addr(ring_base, idx, OFF_D);
					end
				end
				ST_WAIT_END: begin
					if (mac_frame_done || mac_underflow) begin
						stop_req <= mac_underflow;
						state <= ST_WR_D;
						mem_write <= 1'b1;
						mem_addr <= desc_addr(ring_base, idx, OFF_D);
					end
				end
				ST_WR_D: begin
					// Request raised a cycle late, so faults of the last edge are in the word
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_wdata <= d_word;
					end else if (mem_ack) begin
						state <= ST_WR_B;
						mem_addr <= desc_addr(ring_base, idx, OFF_B);
						mem_wdata <= b_word;
					end
				end
				ST_WR_B: begin
					mem_wdata <= b_word;
					if (mem_ack) begin
						idx <= step(idx, ring_len);
						if (chain_ok && !word_b[B_LAST] && !stop_req) begin
							word_b <= nxt_b;
							state <= ST_RD_A;
							mem_write <= 1'b0;
							mem_addr <= desc_addr(ring_base, step(idx, ring_len), OFF_A);
						end else begin
							state <= ST_IDLE;
							mem_req <= 1'b0;
							mem_write <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// ***********************************************************
	// Checks
	// ***********************************************************
	AST_OWN_RELEASE: assert property (@(posedge core_clk) disable iff (reset)
		(state == ST_WR_B && mem_ack) |-> (mem_write && !mem_wdata[B_OWN] && mem_addr[2:0] == OFF_B[2:0]))
		else $error("ownership not released on word b write");
	AST_STATUS_FIRST: assert property (@(posedge core_clk) disable iff (reset)
		$rose(state == ST_WR_B) |-> $past(state == ST_WR_D && mem_ack))
		else $error("ownership released before status write");
	AST_SUMMARY: assert property (@(posedge core_clk) disable iff (reset)
		(state == ST_WR_B && mem_ack) |-> mem_wdata[B_ERR] == (f_data_starved_fault | f_late_collision_fault | f_carrier_lost_fault | f_retry_limit_fault))
		else $error("summary fault not the OR of faults");
	AST_RESERVED: assert property (@(posedge core_clk) disable iff (reset)
		(state == ST_WR_D && mem_ack) |-> (mem_write && !mem_wdata[D_RES]))
		else $error("reserved status bit written as one");
	AST_CHAIN_STOP: assert property (@(posedge core_clk) disable iff (reset)
		$rose(f_chain) |-> (f_data_starved_fault && !transmitter_active))
		else $error("chain fault left transmitter running");
	AST_SKIP: assert property (@(posedge core_clk) disable iff (reset)
		(state == ST_RD_B && mem_ack && mem_rdata[B_OWN] && !mem_rdata[B_FIRST]) |=> (state == ST_IDLE && !mem_req))
		else $error("entry without first flag not skipped");
	AST_LENGTH: assert property (@(posedge core_clk) disable iff (reset)
		(state == ST_RD_C && mem_ack) |=> (xfer_start && xfer_len == 12'(12'h000 - $past(mem_rdata[11:0]))))
		else $error("transfer length not the negated count");
	AST_ADDRESS: assert property (@(posedge core_clk) disable iff (reset)
		xfer_start |-> (xfer_addr == {word_b[7:0], word_a}))
		else $error("buffer address badly formed");
	AST_CHAIN_MASK: assert property (@(posedge core_clk) disable iff (reset)
		(state == ST_WR_D && mem_ack && (f_late_collision_fault || f_retry_limit_fault)) |-> !mem_wdata[D_CHAIN])
		else $error("chain fault reported with late collision or retry limit");
	AST_FIXED: assert property (@(posedge core_clk) disable iff (reset)
		(state == ST_WR_B && mem_ack) |-> (mem_wdata[B_FIRST:0] == word_b[B_FIRST:0]))
		else $error("host owned fields modified");
	AST_RETRY: assert property (@(posedge core_clk) disable iff (reset)
		(in_frame && !frame_end && mac_collision && !f_retry_limit_fault && f_cnt == 5'h0f) |=> f_retry_limit_fault)
		else $error("retry limit not raised after sixteen failures");
endmodule

// >>> tdh_host_mem.sv
// Host memory model holding the transmit descriptor ring
`timescale 1ns/100ps
module tdh_host_mem (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	// ***********************************************************
	// Ring storage, filled by the host before handing entries over
	// ***********************************************************
	// Host sets ownership last and leaves handed entries alone
	logic [15:0] mem [0:127];
	logic [2:0] wait_cnt;
	logic slow;

	// Empty ring at start, so no entry is owned by the controller
	initial begin
		for (int i = 0; i < 128; i++)
			mem[i] = 16'h0000;
	end

	// Answers alternate prompt and slow; a released data line toggles
	always @(posedge core_clk) begin
		if (reset) begin
			mem_ack <= 1'b0;
			wait_cnt <= 3'h0;
			slow <= 1'b0;
			mem_rdata <= 16'h5a5a;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata; // Stale data never looks valid
			wait_cnt <= 3'h0;
			slow <= ~slow;
		end else if (mem_req && wait_cnt >= {slow, 2'b00}) begin
			mem_ack <= 1'b1;
			if (mem_write)
				mem[mem_addr[7:1]] <= mem_wdata;
			else
				mem_rdata <= mem[mem_addr[7:1]];
		end else if (mem_req) begin
			wait_cnt <= wait_cnt + 3'h1;
		end
	end
endmodule

// >>> tdh_pkg.sv
// Constants, field layout and state type for the transmit descriptor handler
package tdh_pkg;
	// ***********************************************************
	// Descriptor word b: ownership, summary and frame flags
	// ***********************************************************
	localparam int B_OWN = 15;
	localparam int B_ERR = 14;
	localparam int B_FORCE = 13;
	localparam int B_MORE = 12;
	localparam int B_ONE = 11;
	localparam int B_WAITED = 10;
	localparam int B_FIRST = 9;
	localparam int B_LAST = 8;
	// ***********************************************************
	// Descriptor words c and d
	// ***********************************************************
	localparam int C_LEN_HI = 11;
	localparam int D_CHAIN = 15;
	localparam int D_STARVED = 14;
	localparam int D_RES = 13;
	localparam int D_LATE_COLLISION_FAULT = 12;
	localparam int D_CARRIER_LOST_FAULT = 11;
	localparam int D_RETRY_LIMIT_FAULT = 10;
	// Byte offsets of the four 16-bit words inside one ring entry
	localparam logic [23:0] OFF_A = 24'h000000;
	localparam logic [23:0] OFF_B = 24'h000002;
	localparam logic [23:0] OFF_C = 24'h000004;
	localparam logic [23:0] OFF_D = 24'h000006;
	localparam int DESC_SHIFT = 3;
	localparam logic [4:0] RETRY_LIMIT = 5'h10;
	// ***********************************************************
	// Register map and reset values
	// ***********************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_RING_BASE = 4'h4;
	localparam logic [3:0] REG_RING_LEN = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam int CTRL_START = 0;
	localparam int CTRL_NO_RETRY = 1;
	localparam int CTRL_CS_DIS = 2;
	localparam logic [7:0] RING_LEN_RST = 8'h08;
	localparam logic [23:0] RING_BASE_RST = 24'h000000;
	typedef enum {ST_IDLE, ST_RD_B, ST_RD_A, ST_RD_C, ST_MOVE, ST_NEXT_B, ST_WAIT_END, ST_WR_D, ST_WR_B} tdh_state_e;
endpackage
